/* verilog/ldi_pkg.sv */
package ldi_pkg;
	// upper five bits of the target address
	localparam logic [4:0] FIXED_ADDRESS_BITS = 5'h0D;
	localparam int         RW_SELECT_BIT      = 0;
	localparam logic       RW_WRITE           = 1'b0;
	localparam logic       RW_READ            = 1'b1;

	// strap pin connection as presented on strap_conn_i
	localparam logic [1:0] STRAP_CONN_GND = 2'h0;
	localparam logic [1:0] STRAP_CONN_VCC = 2'h1;
	localparam logic [1:0] STRAP_CONN_SCL = 2'h2;
	localparam logic [1:0] STRAP_CONN_SDA = 2'h3;

	// resulting strap_address_bits
	localparam logic [1:0] STRAP_BITS_GND = 2'h0;
	localparam logic [1:0] STRAP_BITS_VCC = 2'h3;
	localparam logic [1:0] STRAP_BITS_SCL = 2'h1;
	localparam logic [1:0] STRAP_BITS_SDA = 2'h2;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [7:0] RELEASED_BYTE = 8'hFF;

	localparam int CLK_PERIOD_NS     = 4;
	localparam int SCL_MIN_PERIOD_NS = 1000;
	// one quarter of an scl period, rounded up so scl never exceeds its limit
	localparam int SCL_QTR_CYC = (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

	function automatic logic [1:0] ldi_strap_bits(input logic [1:0] conn);
		unique case (conn)
			STRAP_CONN_GND: ldi_strap_bits = STRAP_BITS_GND;
			STRAP_CONN_VCC: ldi_strap_bits = STRAP_BITS_VCC;
			STRAP_CONN_SCL: ldi_strap_bits = STRAP_BITS_SCL;
			default:        ldi_strap_bits = STRAP_BITS_SDA;
		endcase
	endfunction : ldi_strap_bits
endpackage : ldi_pkg

/* verilog/ldi_if.sv */
`timescale 1ns/1ps
interface ldi_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// wired-and with pull-up: any enabled low driver pulls the line down
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	// the target only listens to scl
	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);
	modport host (
		output scl,
		output host_sda_o,
		output host_sda_oe,
		input  sda
	);
endinterface : ldi_if

/* verilog/ldi_controller.sv */
`timescale 1ns/1ps
module ldi_controller
	import ldi_pkg::*;
#(
	parameter int QTR_CYC = SCL_QTR_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	ldi_if.host             bus,
	input  wire logic       cmd_valid_i,
	input  wire logic       cmd_read_i,
	input  wire logic [6:0] cmd_taddr_i,
	input  wire logic [7:0] cmd_reg_i,
	input  wire logic [7:0] cmd_wdata_i,
	output logic            cmd_ready_o,
	output logic            done_o,
	output logic            nack_o,
	output logic [7:0]      rdata_o
);
	localparam int DW = (QTR_CYC > 1) ? $clog2(QTR_CYC) : 1;

	initial begin
		if (QTR_CYC < 4) begin
			$error("QTR_CYC too small for the target's input synchronisers");
		end
	end

	typedef enum logic [3:0] {
		H_IDLE  = 4'h1,
		H_START = 4'h2,
		H_BYTE  = 4'h4,
		H_STOP  = 4'h8
	} ldi_host_state_type;

	ldi_host_state_type st_ff, nxt_st;
	logic [DW-1:0] div_ff, nxt_div;
	logic [1:0]    q_ff, nxt_q, idx_ff, nxt_idx, sync_ff, nxt_sync;
	logic [3:0]    bit_ff, nxt_bit;
	logic [6:0]    taddr_ff, nxt_taddr;
	logic [7:0]    reg_ff, nxt_reg, wdata_ff, nxt_wdata, shift_ff, nxt_shift;
	logic [7:0]    rdata_ff, nxt_rdata;
	logic          rd_ff, nxt_rd, scl_ff, nxt_scl, oe_ff, nxt_oe;
	logic          nack_ff, nxt_nack, ready_ff, nxt_ready, done_ff, nxt_done;
	logic          tick, rx, last;

	function automatic logic [7:0] byte_of(input logic [1:0] idx);
		unique case (idx)
			2'h0:    byte_of = {taddr_ff, RW_WRITE};
			2'h1:    byte_of = reg_ff;
			2'h2:    byte_of = rd_ff ? {taddr_ff, RW_READ} : wdata_ff;
			default: byte_of = RELEASED_BYTE;
		endcase
	endfunction : byte_of

	always_comb begin
		tick = (div_ff == DW'(QTR_CYC - 1));
		rx   = rd_ff && (idx_ff == 2'h3);
		last = (!rd_ff && (idx_ff == 2'h2)) || rx;
		nxt_st = st_ff; nxt_div = div_ff; nxt_q = q_ff; nxt_idx = idx_ff;
		nxt_sync = {sync_ff[0], bus.sda};
		nxt_bit = bit_ff; nxt_taddr = taddr_ff; nxt_reg = reg_ff; nxt_wdata = wdata_ff;
		nxt_shift = shift_ff; nxt_rdata = rdata_ff; nxt_rd = rd_ff; nxt_scl = scl_ff;
		nxt_oe = oe_ff; nxt_nack = nack_ff; nxt_ready = ready_ff; nxt_done = 1'b0;
		if (st_ff == H_IDLE) begin
			nxt_scl = 1'b1;
			nxt_oe  = 1'b0;
			// ready comes up on the first enabled edge out of reset and after each stop
			nxt_ready = 1'b1;
			if (cmd_valid_i && ready_ff) begin
				nxt_ready = 1'b0;
				nxt_taddr = cmd_taddr_i;
				nxt_reg   = cmd_reg_i;
				nxt_wdata = cmd_wdata_i;
				nxt_rd    = cmd_read_i;
				nxt_st    = H_START;
				nxt_div   = '0;
				nxt_q     = 2'h0;
				nxt_idx   = 2'h0;
				nxt_nack  = 1'b0;
			end
		end else begin
			nxt_div = tick ? '0 : div_ff + 1'b1;
			if (tick) begin
				nxt_q = q_ff + 2'h1;
				unique case (st_ff)
					H_START: begin
						unique case (q_ff)
							2'h0: nxt_oe = 1'b0;
							2'h1: nxt_scl = 1'b1;
							2'h2: nxt_oe = 1'b1;
							default: begin
								nxt_scl   = 1'b0;
								nxt_st    = H_BYTE;
								nxt_bit   = 4'h0;
								nxt_shift = byte_of(idx_ff);
							end
						endcase
					end
					H_BYTE: begin
						unique case (q_ff)
							// data changes only while scl is low
							2'h0: nxt_oe = (bit_ff == BITS_PER_BYTE) ? 1'b0 : ~shift_ff[7];
							2'h1: nxt_scl = 1'b1;
							2'h2: begin
								if (bit_ff != BITS_PER_BYTE) begin
									nxt_shift = {shift_ff[6:0], sync_ff[1]};
								end else if (!rx && sync_ff[1]) begin
									nxt_nack = 1'b1;
								end
							end
							default: begin
								nxt_scl = 1'b0;
								nxt_bit = bit_ff + 4'h1;
								if (bit_ff == BITS_PER_BYTE) begin
									if (nack_ff || last) begin
										nxt_st = H_STOP;
										if (rx) begin
											nxt_rdata = shift_ff;
										end
									end else if (rd_ff && (idx_ff == 2'h1)) begin
										nxt_st  = H_START;
										nxt_idx = 2'h2;
									end else begin
										nxt_idx   = idx_ff + 2'h1;
										nxt_bit   = 4'h0;
										nxt_shift = byte_of(idx_ff + 2'h1);
									end
								end
							end
						endcase
					end
					H_STOP: begin
						unique case (q_ff)
							2'h0: nxt_oe = 1'b1;
							2'h1: nxt_scl = 1'b1;
							2'h2: nxt_oe = 1'b0;
							default: begin
								nxt_st    = H_IDLE;
								nxt_done  = 1'b1;
								nxt_ready = 1'b1;
							end
						endcase
					end
					default: nxt_st = H_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= H_IDLE; div_ff <= '0; q_ff <= 2'h0; idx_ff <= 2'h0; sync_ff <= 2'h3;
			bit_ff <= 4'h0; taddr_ff <= 7'h00; reg_ff <= 8'h00; wdata_ff <= 8'h00;
			shift_ff <= 8'h00; rdata_ff <= 8'h00; rd_ff <= 1'b0; scl_ff <= 1'b1;
			oe_ff <= 1'b0; nack_ff <= 1'b0; ready_ff <= 1'b0; done_ff <= 1'b0;
		end else if (ce_i) begin
			st_ff <= nxt_st; div_ff <= nxt_div; q_ff <= nxt_q; idx_ff <= nxt_idx;
			sync_ff <= nxt_sync; bit_ff <= nxt_bit; taddr_ff <= nxt_taddr;
			reg_ff <= nxt_reg; wdata_ff <= nxt_wdata; shift_ff <= nxt_shift;
			rdata_ff <= nxt_rdata; rd_ff <= nxt_rd; scl_ff <= nxt_scl; oe_ff <= nxt_oe;
			nack_ff <= nxt_nack; ready_ff <= nxt_ready; done_ff <= nxt_done;
		end
	end

	assign bus.scl         = scl_ff;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = oe_ff;
	assign cmd_ready_o     = ready_ff;
	assign done_o          = done_ff;
	assign nack_o          = nack_ff;
	assign rdata_o         = rdata_ff;
endmodule : ldi_controller

/* verilog/ldi_target.sv */
//
// Overview of operation
// - answer seven-bit address, low bit is direction
// - direction zero writes, one reads
// - address is 01101, strap bits, direction
// - strap connection selects the two address bits
// - sample data while clock is high
// - controller leaves data released when idle
// - data falling with clock high starts
// - compare received address after every start
// - controller sends address byte msb first
// - controller releases data for acknowledge clock
// - matching address: hold data low during acknowledge
// - no acknowledge: controller stops and abandons
// - register address byte follows, acknowledged
// - data byte follows msb first, acknowledged
// - data rising with clock high stops
// - target never drives clock, data open-drain
// - controller keeps clock at most 1MHz; only with QTR_CYC of 63 or more, the testbench uses 8
// - pointer increments during each data acknowledge
// - read: write pointer, restart, address with one
`timescale 1ns/1ps
module ldi_target
	import ldi_pkg::*;
#(
	parameter int REG_AW = 8
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	ldi_if.dev                     bus,
	input  wire logic [1:0]        strap_conn_i,
	output logic                   wr_en_o,
	output logic [REG_AW-1:0]      wr_addr_o,
	output logic [7:0]             wr_data_o,
	output logic [REG_AW-1:0]      rd_addr_o,
	input  wire logic [7:0]        rd_data_i,
	output logic                   selected_o
);
	initial begin
		if ((REG_AW < 1) || (REG_AW > 8)) begin
			$error("REG_AW must lie between 1 and 8");
		end
	end

	typedef enum logic [9:0] {
		ST_IDLE      = 10'h001,
		ST_ADDR      = 10'h002,
		ST_ADDR_ACK  = 10'h004,
		ST_REG       = 10'h008,
		ST_REG_ACK   = 10'h010,
		ST_WDATA     = 10'h020,
		ST_WDATA_ACK = 10'h040,
		ST_RDATA     = 10'h080,
		ST_RDATA_ACK = 10'h100,
		ST_IGNORE    = 10'h200
	} ldi_tgt_state_type;

	ldi_tgt_state_type st_ff, nxt_st;
	logic [1:0]        scl_sync_ff, nxt_scl_sync;
	logic [1:0]        sda_sync_ff, nxt_sda_sync;
	logic              scl_q_ff, nxt_scl_q;
	logic              sda_q_ff, nxt_sda_q;
	logic [7:0]        shift_ff, nxt_shift;
	logic [3:0]        cnt_ff, nxt_cnt;
	logic [REG_AW-1:0] ptr_ff, nxt_ptr;
	logic              rw_ff, nxt_rw;
	logic              oe_ff, nxt_oe;
	logic              wr_en_ff, nxt_wr_en;
	logic [REG_AW-1:0] wr_addr_ff, nxt_wr_addr;
	logic [7:0]        wr_data_ff, nxt_wr_data;
	logic [6:0]        own_addr_ff, nxt_own_addr;
	logic [3:0]        strap_sync_ff, nxt_strap_sync;
	logic              sel_ff, nxt_sel;
	logic              scl_s, sda_s, rise, fall, start_seen, stop_seen;

	always_comb begin
		// only the second synchroniser stage and its delayed copy feed logic
		scl_s      = scl_sync_ff[1];
		sda_s      = sda_sync_ff[1];
		rise       = scl_s & ~scl_q_ff;
		fall       = ~scl_s & scl_q_ff;
		start_seen = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
		stop_seen  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

		nxt_scl_sync   = {scl_sync_ff[0], bus.scl};
		nxt_sda_sync   = {sda_sync_ff[0], bus.sda};
		nxt_scl_q      = scl_s;
		nxt_sda_q      = sda_s;
		nxt_st         = st_ff;
		nxt_shift      = shift_ff;
		nxt_cnt        = cnt_ff;
		nxt_ptr        = ptr_ff;
		nxt_rw         = rw_ff;
		nxt_oe         = oe_ff;
		nxt_wr_en      = 1'b0;
		nxt_wr_addr    = wr_addr_ff;
		nxt_wr_data    = wr_data_ff;
		// strap is a pin: two stages first, and it must stand still while in use
		nxt_strap_sync = {strap_sync_ff[1:0], strap_conn_i};
		nxt_own_addr   = {FIXED_ADDRESS_BITS, ldi_strap_bits(strap_sync_ff[3:2])};

		if (start_seen) begin
			// a repeated start also lands here and re-arms address matching
			nxt_st  = ST_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe  = 1'b0;
		end else if (stop_seen) begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'b0;
		end else begin
			unique case (st_ff)
				ST_IDLE, ST_IGNORE: begin
					nxt_oe = 1'b0;
				end
				ST_ADDR, ST_REG, ST_WDATA: begin
					if (rise && (cnt_ff != BITS_PER_BYTE)) begin
						nxt_shift = {shift_ff[6:0], sda_s};
						nxt_cnt   = cnt_ff + 4'h1;
					end else if (fall && (cnt_ff == BITS_PER_BYTE)) begin
						unique case (st_ff)
							ST_ADDR: begin
								if (shift_ff[7:1] == own_addr_ff) begin
									nxt_st = ST_ADDR_ACK;
									nxt_oe = 1'b1;
									nxt_rw = shift_ff[RW_SELECT_BIT];
								end else begin
									nxt_st = ST_IGNORE;
								end
							end
							ST_REG: begin
								nxt_ptr = shift_ff[REG_AW-1:0];
								nxt_st  = ST_REG_ACK;
								nxt_oe  = 1'b1;
							end
							default: begin
								nxt_wr_en   = 1'b1;
								nxt_wr_addr = ptr_ff;
								nxt_wr_data = shift_ff;
								nxt_ptr     = ptr_ff + 1'b1;
								nxt_st      = ST_WDATA_ACK;
								nxt_oe      = 1'b1;
							end
						endcase
					end
				end
				ST_ADDR_ACK: begin
					if (fall) begin
						nxt_cnt = 4'h0;
						if (rw_ff == RW_READ) begin
							// first data bit goes out on the same falling edge
							nxt_st    = ST_RDATA;
							nxt_shift = rd_data_i;
							nxt_oe    = ~rd_data_i[7];
						end else begin
							nxt_st = ST_REG;
							nxt_oe = 1'b0;
						end
					end
				end
				ST_REG_ACK, ST_WDATA_ACK: begin
					if (fall) begin
						nxt_st  = ST_WDATA;
						nxt_cnt = 4'h0;
						nxt_oe  = 1'b0;
					end
				end
				ST_RDATA: begin
					if (fall) begin
						if (cnt_ff == LAST_DATA_BIT) begin
							nxt_st  = ST_RDATA_ACK;
							nxt_oe  = 1'b0;
							nxt_ptr = ptr_ff + 1'b1;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'b0};
							nxt_oe    = ~shift_ff[6];
							nxt_cnt   = cnt_ff + 4'h1;
						end
					end
				end
				ST_RDATA_ACK: begin
					if (rise && sda_s) begin
						// controller declined more data: wait for its stop
						nxt_st = ST_IGNORE;
					end else if (fall) begin
						nxt_st    = ST_RDATA;
						nxt_cnt   = 4'h0;
						nxt_shift = rd_data_i;
						nxt_oe    = ~rd_data_i[7];
					end
				end
				default: begin
					nxt_st = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
		nxt_sel = (nxt_st != ST_IDLE) && (nxt_st != ST_IGNORE) && (nxt_st != ST_ADDR);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff         <= ST_IDLE;
			scl_sync_ff   <= 2'h3;
			sda_sync_ff   <= 2'h3;
			scl_q_ff      <= 1'b1;
			sda_q_ff      <= 1'b1;
			shift_ff      <= 8'h00;
			cnt_ff        <= 4'h0;
			ptr_ff        <= '0;
			rw_ff         <= 1'b0;
			oe_ff         <= 1'b0;
			wr_en_ff      <= 1'b0;
			wr_addr_ff    <= '0;
			wr_data_ff    <= 8'h00;
			own_addr_ff   <= 7'h00;
			strap_sync_ff <= 4'h0;
			sel_ff        <= 1'b0;
		end else if (ce_i) begin
			st_ff         <= nxt_st;
			scl_sync_ff   <= nxt_scl_sync;
			sda_sync_ff   <= nxt_sda_sync;
			scl_q_ff      <= nxt_scl_q;
			sda_q_ff      <= nxt_sda_q;
			shift_ff      <= nxt_shift;
			cnt_ff        <= nxt_cnt;
			ptr_ff        <= nxt_ptr;
			rw_ff         <= nxt_rw;
			oe_ff         <= nxt_oe;
			wr_en_ff      <= nxt_wr_en;
			wr_addr_ff    <= nxt_wr_addr;
			wr_data_ff    <= nxt_wr_data;
			own_addr_ff   <= nxt_own_addr;
			strap_sync_ff <= nxt_strap_sync;
			sel_ff        <= nxt_sel;
		end
	end

	// open-drain: the pin is only ever pulled low, scl is never driven
	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = oe_ff;
	assign wr_en_o        = wr_en_ff;
	assign wr_addr_o      = wr_addr_ff;
	assign wr_data_o      = wr_data_ff;
	assign rd_addr_o      = ptr_ff;
	assign selected_o     = sel_ff;
endmodule : ldi_target

/* tb/ldi_checker.sv */
`timescale 1ns/1ps
module ldi_checker #(
	parameter int QTR_CYC = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	// bounds only hold for QTR_CYC up to 32768; a long ce pause would need DRIVE_MAX raised
	localparam int HALF_MIN  = 2 * QTR_CYC - 1;
	localparam int START_MAX = QTR_CYC + 4;
	localparam int DRIVE_MAX = 48 * QTR_CYC;
	logic [15:0] hi_cnt_ff;
	logic [15:0] nxt_hi_cnt;
	logic [15:0] lo_cnt_ff;
	logic [15:0] nxt_lo_cnt;

	always_comb begin
		nxt_hi_cnt = (!scl) ? 16'h0 : ((&hi_cnt_ff) ? hi_cnt_ff : hi_cnt_ff + 16'h1);
		nxt_lo_cnt = scl ? 16'h0 : ((&lo_cnt_ff) ? lo_cnt_ff : lo_cnt_ff + 16'h1);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_cnt_ff <= 16'h0;
			lo_cnt_ff <= 16'h0;
		end else begin
			hi_cnt_ff <= nxt_hi_cnt;
			lo_cnt_ff <= nxt_lo_cnt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_start_cond;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence s_stop_cond;
		$rose(sda) && scl && $past(scl);
	endsequence

	a_open_drain: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
		else $error("target drives sda high");
	a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target moved sda while scl high");
	a_ack_hold: assert property (scl && $past(scl) && $past(dev_sda_oe) |-> dev_sda_oe)
		else $error("target let go of sda during scl high");
	a_ack_bound: assert property ($rose(dev_sda_oe) |-> ##[1:DRIVE_MAX] !dev_sda_oe)
		else $error("target holds sda too long");
	a_no_clash: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
		else $error("both ends drive sda while scl high");
	a_start_form: assert property (s_start_cond |-> ##[1:START_MAX] !scl)
		else $error("start not followed by scl low");
	a_stop_idle: assert property (s_stop_cond |=> (scl && sda) [*4])
		else $error("bus not idle after stop");
	a_scl_high_min: assert property ($fell(scl) |-> hi_cnt_ff >= HALF_MIN)
		else $error("scl high phase too short");
	a_scl_low_min: assert property ($rose(scl) |-> lo_cnt_ff >= HALF_MIN)
		else $error("scl low phase too short");
endmodule : ldi_checker

/* tb/led_driver_i2c_target_port_tb.sv */
`timescale 1ns/1ps
module led_driver_i2c_target_port_tb;
	import ldi_pkg::*;
	localparam int QTR      = 8;
	localparam int WAIT_MAX = 20000;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        ce_i = 1'b1;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_read_i = 1'b0;
	logic [6:0]  cmd_taddr_i = 7'h0;
	logic [7:0]  cmd_reg_i = 8'h0;
	logic [7:0]  cmd_wdata_i = 8'h0;
	logic [1:0]  strap_conn_i = 2'h0;
	logic        cmd_ready_o, done_o, nack_o, wr_en_o, selected_o;
	logic [7:0]  rdata_o, wr_addr_o, wr_data_o, rd_addr_o, rd_data_i;
	logic [7:0]  regs [256];
	logic [7:0]  model_mem [256];
	logic [7:0]  exp_addr_q [$];
	logic [7:0]  exp_data_q [$];
	logic [1:0]  conn_tab [4] = '{STRAP_CONN_GND, STRAP_CONN_VCC, STRAP_CONN_SCL, STRAP_CONN_SDA};
	logic [1:0]  bits_tab [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
	logic        sel_seen = 1'b0;
	logic        scl_q = 1'b1;
	logic        sda_q = 1'b1;
	logic [3:0]  bit_n = 4'h8;
	logic [7:0]  shift_q = 8'h0;
	logic [7:0]  addr_byte = 8'h0;
	logic [31:0] rng = 32'h92ae_c6ac;
	logic [6:0]  own;
	int          mismatches = 0;
	int          tests_run = 0;

	ldi_if bus_if ();
	ldi_controller #(.QTR_CYC(QTR)) ldi_controller_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce_i), .bus(bus_if), .cmd_valid_i(cmd_valid_i), .cmd_read_i(cmd_read_i),
		.cmd_taddr_i(cmd_taddr_i), .cmd_reg_i(cmd_reg_i), .cmd_wdata_i(cmd_wdata_i),
		.cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o), .rdata_o(rdata_o));
	ldi_target ldi_target_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .bus(bus_if),
		.strap_conn_i(strap_conn_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
		.selected_o(selected_o));
	ldi_checker #(.QTR_CYC(QTR)) ldi_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.scl(bus_if.scl), .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda));

	// half period of the 250 MHz clock
	always #2 clk_i = ~clk_i;
	assign rd_data_i = regs[rd_addr_o];

	function automatic logic [31:0] xs_step(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs_step = t ^ (t << 5);
	endfunction : xs_step

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// register file side plus a wire-level sniffer of the byte after each start
	always @(posedge clk_i) begin
		scl_q <= bus_if.scl;
		sda_q <= bus_if.sda;
		if (selected_o === 1'b1)
			sel_seen <= 1'b1;
		if (bus_if.scl && scl_q && sda_q && !bus_if.sda) begin
			bit_n <= 4'h0;
		end else if (bus_if.scl && !scl_q && bit_n < 4'h8) begin
			shift_q <= {shift_q[6:0], bus_if.sda};
			bit_n <= bit_n + 4'h1;
			if (bit_n == 4'h7)
				addr_byte <= {shift_q[6:0], bus_if.sda};
		end
		if (wr_en_o === 1'b1) begin
			regs[wr_addr_o] <= wr_data_o;
			if (exp_addr_q.size() == 0) begin
				chk(16'h1, 16'h0);
			end else begin
				chk({8'h0, wr_addr_o}, {8'h0, exp_addr_q.pop_front()});
				chk({8'h0, wr_data_o}, {8'h0, exp_data_q.pop_front()});
			end
		end
	end

	task automatic do_reset(input int k);
		rst_n_i <= 1'b0;
		strap_conn_i <= conn_tab[k];
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		own = {5'h0d, bits_tab[k]};
	endtask : do_reset

	task automatic run_cmd(input logic rd, input logic [6:0] ta, input logic [7:0] ra,
			input logic [7:0] wd);
		int  n;
		logic ok;
		ok = (ta == own);
		if (!rd && ok) begin
			exp_addr_q.push_back(ra);
			exp_data_q.push_back(wd);
			model_mem[ra] = wd;
		end
		sel_seen <= 1'b0;
		cmd_valid_i <= 1'b1;
		cmd_read_i <= rd;
		cmd_taddr_i <= ta;
		cmd_reg_i <= ra;
		cmd_wdata_i <= wd;
		for (n = 0; n < WAIT_MAX; n++) begin
			@(posedge clk_i);
			if (cmd_ready_o === 1'b1 && ce_i === 1'b1)
				break;
		end
		if (n == WAIT_MAX) begin
			mismatches++;
			conclude();
		end
		cmd_valid_i <= 1'b0;
		for (n = 0; n < WAIT_MAX; n++) begin
			@(posedge clk_i);
			if (done_o === 1'b1)
				break;
		end
		if (n == WAIT_MAX) begin
			mismatches++;
			conclude();
		end
		chk({15'h0, nack_o}, {15'h0, !ok});
		chk({15'h0, sel_seen}, {15'h0, ok});
		chk({8'h0, addr_byte}, {8'h0, ta, ok & rd});
		chk({14'h0, bus_if.scl, bus_if.sda}, 16'h3);
		if (rd && ok)
			chk({8'h0, rdata_o}, {8'h0, model_mem[ra]});
		chk(exp_addr_q.size(), 16'h0);
	endtask : run_cmd

	initial begin
		logic [7:0] ra;
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'(i) ^ 8'ha5;
			model_mem[i] = 8'(i) ^ 8'ha5;
		end
		for (int k = 0; k < 4; k++) begin
			do_reset(k);
			for (int j = 0; j < 2; j++) begin
				rng = xs_step(rng);
				ra = rng[7:0];
				if (k == 2 && j == 0) begin
					// freeze both ends mid-transfer; the transfer must resume intact
					fork
						run_cmd(1'b0, own, ra, rng[15:8]);
						begin
							repeat (100) @(posedge clk_i);
							ce_i <= 1'b0;
							repeat (50) @(posedge clk_i);
							ce_i <= 1'b1;
						end
					join
				end else begin
					run_cmd(1'b0, own, ra, rng[15:8]);
				end
			end
			run_cmd(1'b1, own, ra, 8'h0);
			rng = xs_step(rng);
			run_cmd(1'b0, own ^ (7'h1 << (rng[7:0] % 7)), rng[15:8], rng[23:16]);
			run_cmd(1'b1, own, rng[31:24], 8'h0);
		end
		conclude();
	end
endmodule : led_driver_i2c_target_port_tb
